/* logic/sart_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sart_cfg.svh"

module sart_top
    import sart_pkg::*;
#(
    parameter int WORD_W = `SART_WORD_W,
    parameter int FIFO_DEPTH = `SART_FIFO_DEPTH,
    parameter int CONV_SCLKS = `SART_CONV_SCLKS
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clk_i,
    input wire logic power_down_i,
    input wire sart_word_t sample_i,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    output logic serial_result_out_o,
    output logic serial_result_oe_o,
    output logic powered_up_o,
    output sart_event_s event_o
);

    sart_state_e state;
    sart_line_s line;
    sart_event_s event_q;
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic cs_fall;
    logic cs_high;
    logic sclk_fall;
    logic [4:0] bit_cnt;
    sart_word_t shifter;
    logic [7:0] quiet_cnt;
    logic [7:0] wake_cnt;
    logic start;
    logic head_valid;
    sart_word_t head_data;
    logic pop;
    sart_word_t first_word;
    logic shift_step;
    logic last_fall;
    logic frame_abort;
    logic read_end;

    // Stage 0 feeds only stage 1; edges are found between stages 1 and 2
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cs_sync <= 3'h7;
            sclk_sync <= 3'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], chip_select_n_i};
            sclk_sync <= {sclk_sync[1:0], serial_clk_i};
        end
    end

    // Falling edge seen between the settled sampler stages
    function automatic logic edge_fell(input logic [2:0] s);
        return s[2] && !s[1];
    endfunction

    // True for the fall that closes the frame's last bit period
    function automatic logic is_last(input logic [4:0] cnt);
        return cnt == 5'(CONV_SCLKS - 1);
    endfunction

    assign cs_fall = edge_fell(cs_sync);
    assign cs_high = cs_sync[1];
    assign sclk_fall = edge_fell(sclk_sync);
    assign start = (state == SART_IDLE) && cs_fall && powered_up_o;
    // The sampler costs two to three system clocks per pin edge; the nanosecond
    // pin delays cannot be met this way, only the order of events is kept
    assign shift_step = (state == SART_SHIFT) && !cs_high && sclk_fall;
    assign last_fall = shift_step && is_last(bit_cnt);
    assign frame_abort = (state == SART_SHIFT) && cs_high;
    assign read_end = last_fall || frame_abort;
    // An empty buffer still runs the frame with zeros, so the host never stalls
    assign first_word = head_valid ? head_data : '0;
    // A word is taken only when a frame really starts
    assign pop = start && head_valid;

    sart_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .in_data_i(sample_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(sample_ready_o),
        .out_data_o(head_data),
        .out_valid_o(head_valid),
        .out_ready_i(pop)
    );

    // Wake timer: results are held back until the converter has settled
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_cnt <= 8'(`SART_PWRUP_CYC);
            powered_up_o <= 1'b0;
        end else if (power_down_i) begin
            wake_cnt <= 8'(`SART_PWRUP_CYC);
            powered_up_o <= 1'b0;
        end else if (wake_cnt != 8'h00) begin
            wake_cnt <= wake_cnt - 8'h01;
            powered_up_o <= 1'b0;
        end else begin
            powered_up_o <= 1'b1;
        end
    end

    // Frame sequencer
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= SART_IDLE;
        end else begin
            case (state)
                SART_IDLE: begin
                    if (start) begin
                        state <= SART_SHIFT;
                    end
                end
                SART_SHIFT: begin
                    if (frame_abort) begin
                        // Early abort: the line is released at once
                        state <= SART_IDLE;
                    end else if (last_fall) begin
                        state <= SART_DONE;
                    end
                end
                SART_DONE: begin
                    // Extra serial clocks in the frame are ignored; wait for deselect
                    if (cs_high) begin
                        state <= SART_IDLE;
                    end
                end
                default: begin
                    state <= SART_IDLE;
                end
            endcase
        end
    end

    // Result line: driven only while a frame shifts, so no state can leave it enabled
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            line <= '0;
        end else if (start) begin
            line.oe <= 1'b1;
            line.data <= first_word[WORD_W-1];
        end else if (state != SART_SHIFT || read_end) begin
            line <= '0;
        end else if (sclk_fall) begin
            line.data <= shifter[WORD_W-1];
        end
    end

    // Count of detected falls in the running frame
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_cnt <= '0;
        end else if (start) begin
            bit_cnt <= '0;
        end else if (shift_step) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Remaining bits of the word, leading bit first
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shifter <= '0;
        end else if (start) begin
            shifter <= first_word << 1;
        end else if (shift_step && !is_last(bit_cnt)) begin
            shifter <= shifter << 1;
        end
    end

    // Quiet-gap timer after each read, checked against the next frame start
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            quiet_cnt <= 8'h00;
        end else if (read_end) begin
            quiet_cnt <= 8'(`SART_QUIET_CYC);
        end else if (quiet_cnt != 8'h00) begin
            quiet_cnt <= quiet_cnt - 8'h01;
        end
    end

    // One-cycle event pulses for the user side
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_q <= '0;
        end else begin
            event_q.frame_done <= last_fall;
            event_q.short_frame <= frame_abort;
            event_q.gap_violation <= cs_fall && (quiet_cnt != 8'h00);
            event_q.underrun <= start && !head_valid;
        end
    end

    assign serial_result_out_o = line.data;
    assign serial_result_oe_o = line.oe;
    assign event_o = event_q;

endmodule

`default_nettype wire

/* logic/sart_cfg.svh */
`ifndef SART_CFG_SVH
`define SART_CFG_SVH

// Serial clock periods per conversion frame
`define SART_CONV_SCLKS 16
// System clock period in ns (40 MHz)
`define SART_SYS_CLK_NS 25
// Least idle time between end of a read and the next frame start
`define SART_QUIET_NS 60
`define SART_QUIET_CYC ((`SART_QUIET_NS + `SART_SYS_CLK_NS - 1) / `SART_SYS_CLK_NS)
// Longest wake time from full power-down
`define SART_PWRUP_NS 1000
`define SART_PWRUP_CYC (`SART_PWRUP_NS / `SART_SYS_CLK_NS)
// Result word width and buffer depth
`define SART_WORD_W 16
`define SART_FIFO_DEPTH 4

`endif

/* logic/sart_pkg.sv */
`default_nettype none
`include "sart_cfg.svh"

package sart_pkg;

    typedef logic [`SART_WORD_W-1:0] sart_word_t;

    typedef struct packed {
        logic data;
        logic oe;
    } sart_line_s;

    typedef struct packed {
        logic frame_done;
        logic short_frame;
        logic gap_violation;
        logic underrun;
    } sart_event_s;

    typedef enum logic [1:0] {
        SART_IDLE = 2'b00,
        SART_SHIFT = 2'b01,
        SART_DONE = 2'b10
    } sart_state_e;

endpackage

`default_nettype wire

/* logic/sart_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module sart_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* tb/sart_top_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module sart_top_monitor
    import sart_pkg::*;
#(
    parameter int CONV_SCLKS = 16
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clk_i,
    input wire logic power_down_i,
    input wire logic serial_result_out_o,
    input wire logic serial_result_oe_o,
    input wire logic powered_up_o,
    input wire sart_event_s event_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic sclk_q;
    logic [4:0] falls;
    logic [5:0] wake;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_q <= 1'b0;
            falls <= 5'h0;
        end else begin
            sclk_q <= serial_clk_i;
            if (chip_select_n_i) falls <= 5'h0;
            else if (sclk_q && !serial_clk_i) falls <= falls + 5'h1;
        end
    end
    // Mirrors the wake timer; restarts on reset and on power-down alike
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) wake <= 6'h0;
        else if (power_down_i) wake <= 6'h0;
        else if (wake != 6'h3f) wake <= wake + 6'h1;
    end
    sequence s_oe_ended;
        !serial_result_oe_o && $past(serial_result_oe_o);
    endsequence
    sequence s_done_pulse;
        event_o.frame_done ##1 !event_o.frame_done;
    endsequence
    chk_done_count: assert property ($rose(event_o.frame_done) |-> falls == CONV_SCLKS)
        else $error("frame end without full clock count");
    chk_done_after_oe: assert property ($rose(event_o.frame_done) |-> s_oe_ended and s_done_pulse)
        else $error("frame end not after line release");
    chk_oe_start: assert property (($fell(chip_select_n_i) && powered_up_o) |-> ##[2:4] serial_result_oe_o)
        else $error("line not driven after select");
    chk_oe_in_frame: assert property (serial_result_oe_o |-> !$past(chip_select_n_i, 3) || !$past(chip_select_n_i, 4))
        else $error("line driven outside frame");
    chk_oe_quiet: assert property (!serial_result_oe_o |-> !serial_result_out_o)
        else $error("data set while released");
    chk_bit_after_fall: assert property (($changed(serial_result_out_o) && serial_result_oe_o && $past(serial_result_oe_o))
        |-> $past(serial_clk_i, 4) && !$past(serial_clk_i, 3))
        else $error("bit changed without clock fall");
    chk_pd_drops: assert property (power_down_i |=> !powered_up_o)
        else $error("awake during power-down");
    chk_wake_time: assert property ($rose(powered_up_o) |-> wake inside {[40:42]})
        else $error("wake time wrong");
    chk_awake_start: assert property ($rose(serial_result_oe_o) |-> powered_up_o)
        else $error("frame while asleep");
endmodule
bind sart_top sart_top_monitor #(.CONV_SCLKS(CONV_SCLKS)) u_mon (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .chip_select_n_i(chip_select_n_i), .serial_clk_i(serial_clk_i), .power_down_i(power_down_i),
    .serial_result_out_o(serial_result_out_o), .serial_result_oe_o(serial_result_oe_o),
    .powered_up_o(powered_up_o), .event_o(event_o));
`default_nettype wire

/* tb/sart_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sart_host_model (
    input wire logic sys_clk_i,
    input wire logic line_i,
    input wire logic line_oe_i,
    output logic chip_select_n_o,
    output logic serial_clk_o
);
    logic [15:0] word;
    initial begin
        chip_select_n_o = 1'b1;
        serial_clk_o = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // Clock stands low between frames; 4 high and 4 low cycles give 50/50 duty
    task automatic frame(input int falls, input int gap);
        word = 16'h0;
        chip_select_n_o = 1'b0;
        step(6);
        for (int i = 0; i < falls; i++) begin
            serial_clk_o = 1'b1;
            word = {word[14:0], line_oe_i ? line_i : ~line_i};
            step(4);
            serial_clk_o = 1'b0;
            step(4);
        end
        step(4);
        chip_select_n_o = 1'b1;
        step(gap);
    endtask
endmodule
`default_nettype wire

/* tb/sart_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sart_top_tb_top
    import sart_pkg::*;
;
    logic clk, rst_n, cs_n, sclk, pd, valid, ready, dout, oe, pu;
    sart_word_t sample;
    sart_event_s ev, seen;
    int failures, n_tests;
    sart_top dut (.sys_clk_i(clk), .reset_n_i(rst_n), .chip_select_n_i(cs_n), .serial_clk_i(sclk),
        .power_down_i(pd), .sample_i(sample), .sample_valid_i(valid), .sample_ready_o(ready),
        .serial_result_out_o(dout), .serial_result_oe_o(oe), .powered_up_o(pu), .event_o(ev));
    sart_host_model host (.sys_clk_i(clk), .line_i(dout), .line_oe_i(oe), .chip_select_n_o(cs_n),
        .serial_clk_o(sclk));
    always @(posedge clk) seen <= seen | ev;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check({15'h0, got}, {15'h0, exp});
    endtask
    task automatic push(input sart_word_t w);
        sample = w;
        valid = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic run(input int falls, input sart_word_t exp, input logic [3:0] evx);
        seen = '0;
        host.frame(falls, 8);
        check(host.word, exp);
        check({12'h0, seen}, {12'h0, evx});
        check_bit(oe, 1'b0);
    endtask
    task automatic t_wake;
        repeat (40) @(posedge clk);
        #1;
        check_bit(pu, 1'b0);
        @(posedge clk);
        #1;
        check_bit(pu, 1'b1);
    endtask
    task automatic t_stream;
        sart_word_t w[4] = '{16'ha5c3, 16'h8001, 16'h7ffe, 16'hffff};
        foreach (w[i]) push(w[i]);
        check_bit(ready, 1'b0);
        push(16'h1234);
        valid = 1'b0;
        foreach (w[i]) run(16, w[i], 4'b1000);
        check_bit(ready, 1'b1);
    endtask
    task automatic t_faults;
        run(16, 16'h0000, 4'b1001);
        push(16'hc003);
        valid = 1'b0;
        run(5, 16'h0018, 4'b0100);
    endtask
    // Deselect for one cycle only after a cut frame: the next frame breaks the quiet gap
    task automatic t_gap;
        push(16'h3c00);
        push(16'h5a0f);
        valid = 1'b0;
        seen = '0;
        host.frame(3, 1);
        host.frame(16, 8);
        check(host.word, 16'h5a0f);
        check({12'h0, seen}, {12'h0, 4'b1110});
        check_bit(oe, 1'b0);
    endtask
    task automatic t_sleep;
        pd = 1'b1;
        push(16'h0000);
        valid = 1'b0;
        check_bit(pu, 1'b0);
        run(16, 16'hffff, 4'b0000);
        pd = 1'b0;
        repeat (42) @(posedge clk);
        #1;
        check_bit(pu, 1'b1);
        run(16, 16'h0000, 4'b1000);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        failures = 0;
        n_tests = 0;
        rst_n = 1'b0;
        pd = 1'b0;
        valid = 1'b0;
        sample = '0;
        seen = '0;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_wake();
        t_stream();
        t_faults();
        t_gap();
        t_sleep();
        complete_run();
    end
    // About ten frames of 150 cycles plus wake times; ample margin
    initial begin
        #200000;
        failures++;
        complete_run();
    end
endmodule
`default_nettype wire
